// file: src/xcd_pkg.sv
// package: timing constants, states and carriers for the x-cap discharge sequencer
`default_nettype none
package xcd_pkg;
	localparam int unsigned CLK_HZ       = 200_000_000;
	localparam int unsigned STEP_MS      = 12;
	localparam int unsigned LAST_MS      = 48;
	localparam int unsigned DISCH_MS     = 300;
	localparam int unsigned BLANK_MS     = 700;
	localparam int unsigned DET_MS       = 84;
	localparam int unsigned CYC_PER_MS   = CLK_HZ / 1000;
	localparam int unsigned STEP_CYC     = STEP_MS * CYC_PER_MS;
	localparam int unsigned LAST_CYC     = LAST_MS * CYC_PER_MS;
	localparam int unsigned DISCH_CYC    = DISCH_MS * CYC_PER_MS;
	localparam int unsigned BLANK_CYC    = BLANK_MS * CYC_PER_MS;
	localparam int unsigned TMR_W        = 28;
	localparam int unsigned LVL_W        = 2;
	localparam logic [LVL_W-1:0] LVL_LOW = 2'h0;
	localparam logic [LVL_W-1:0] LVL_TOP = 2'h3;

	typedef enum logic [2:0] {
		XCD_SHORT_CHK = 3'h0,
		XCD_DETECT    = 3'h1,
		XCD_DISCHARGE = 3'h2,
		XCD_BLANK     = 3'h3,
		XCD_WAIT      = 3'h4,
		XCD_DISABLED  = 3'h5
	} xcd_state_type;

	// current commands toward the analog pin drivers
	typedef struct packed {
		logic             test_en;
		logic [LVL_W-1:0] test_lvl;
		logic             disch_en;
		logic             short_src_en;
	} xcd_drive_type;
endpackage
`default_nettype wire

// file: src/xcd_seq.sv
// x-capacitor discharge sequencer: short check, staircase detection, discharge, blanking
//
// Contract
// - a 6.5 V comparator crossing on the pins counts as a line zero-cross event
// - no crossing within 84 ms: discharge at most 300 ms, then 700 ms blanking
// - discharge sink is the 2 mA current, enabled only in discharge
// - discharge current never enabled unless line removal was confirmed
// - detection drives four test-current levels in increasing order
// - first three levels each advance after a 12 ms timeout without crossing
// - fourth level held 48 ms; only then discharge is entered
// - any crossing aborts higher steps and starts a 700 ms wait, no current
// - line-loss latch set on confirmed removal; discharge only while set
// - sequencer keeps running during supply restart cycles after faults
// - at first supply turn-on source 80 uA to test for a ground short
// - pin below 4 V before go first high: disable function permanently
`default_nettype none
module xcd_seq #(
	parameter int unsigned STEP_CYC  = xcd_pkg::STEP_CYC,
	parameter int unsigned LAST_CYC  = xcd_pkg::LAST_CYC,
	parameter int unsigned DISCH_CYC = xcd_pkg::DISCH_CYC,
	parameter int unsigned BLANK_CYC = xcd_pkg::BLANK_CYC
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_rst,
	input  wire logic                  i_vdd_on,
	input  wire logic                  i_zc_cmp,
	input  wire logic                  i_short_cmp,
	input  wire logic                  i_run,
	output logic                       o_test_en,
	output logic [xcd_pkg::LVL_W-1:0]  o_test_lvl,
	output logic                       o_disch_en,
	output logic                       o_short_src_en,
	output logic                       o_line_loss_latch,
	output logic                       o_disabled
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers: three flops, change accepted when stages two and three agree

	logic [2:0] zc_s_q, sh_s_q, run_s_q, vdd_s_q;
	logic       zc_q, sh_q, run_q, vdd_q, zc_prev_q;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			zc_s_q  <= 3'h0;
			sh_s_q  <= 3'h0;
			run_s_q <= 3'h0;
			vdd_s_q <= 3'h0;
		end else begin
			zc_s_q  <= {zc_s_q[1:0], i_zc_cmp};
			sh_s_q  <= {sh_s_q[1:0], i_short_cmp};
			run_s_q <= {run_s_q[1:0], i_run};
			vdd_s_q <= {vdd_s_q[1:0], i_vdd_on};
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			zc_q      <= 1'b0;
			sh_q      <= 1'b0;
			run_q     <= 1'b0;
			vdd_q     <= 1'b0;
			zc_prev_q <= 1'b0;
		end else begin
			if (zc_s_q[1] == zc_s_q[2])
				zc_q <= zc_s_q[2];
			if (sh_s_q[1] == sh_s_q[2])
				sh_q <= sh_s_q[2];
			if (run_s_q[1] == run_s_q[2])
				run_q <= run_s_q[2];
			if (vdd_s_q[1] == vdd_s_q[2])
				vdd_q <= vdd_s_q[2];
			zc_prev_q <= zc_q;
		end
	end

	// comparator output crossing the zero-cross level, either direction
	logic zc_evt;
	assign zc_evt = zc_q ^ zc_prev_q;

////////////////////////////////////////////////////////////////////////////////
// sequencer

	xcd_pkg::xcd_state_type        state_q;
	logic [xcd_pkg::TMR_W-1:0]     tmr_q;
	logic [xcd_pkg::LVL_W-1:0]     lvl_q;
	logic                          latch_q;
	xcd_pkg::xcd_drive_type        drv_d, drv_q;

	function automatic logic expired(input logic [xcd_pkg::TMR_W-1:0] t, input int unsigned n);
		expired = (t >= xcd_pkg::TMR_W'(n - 1));
	endfunction

	logic step_done;
	assign step_done = (lvl_q == xcd_pkg::LVL_TOP) ? expired(tmr_q, LAST_CYC)
		: expired(tmr_q, STEP_CYC);

	// no supply-fault input: restart cycles do not disturb the sequence
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= xcd_pkg::XCD_SHORT_CHK;
			tmr_q   <= '0;
			lvl_q   <= xcd_pkg::LVL_LOW;
			latch_q <= 1'b0;
		end else begin
			tmr_q <= tmr_q + 1'b1;
			unique case (state_q)
				xcd_pkg::XCD_SHORT_CHK: begin
					tmr_q <= '0;
					if (vdd_q && sh_q) begin
						state_q <= xcd_pkg::XCD_DISABLED;
					end else if (vdd_q && run_q) begin
						state_q <= xcd_pkg::XCD_DETECT;
						lvl_q   <= xcd_pkg::LVL_LOW;
					end
				end
				xcd_pkg::XCD_DETECT: begin
					if (zc_evt) begin
						state_q <= xcd_pkg::XCD_WAIT;
						tmr_q   <= '0;
					end else if (step_done) begin
						tmr_q <= '0;
						if (lvl_q == xcd_pkg::LVL_TOP) begin
							state_q <= xcd_pkg::XCD_DISCHARGE;
							latch_q <= 1'b1;
						end else begin
							lvl_q <= lvl_q + 1'b1;
						end
					end
				end
				xcd_pkg::XCD_DISCHARGE: begin
					if (expired(tmr_q, DISCH_CYC)) begin
						state_q <= xcd_pkg::XCD_BLANK;
						tmr_q   <= '0;
						latch_q <= 1'b0;
					end
				end
				xcd_pkg::XCD_BLANK, xcd_pkg::XCD_WAIT: begin
					if (expired(tmr_q, BLANK_CYC)) begin
						state_q <= xcd_pkg::XCD_DETECT;
						tmr_q   <= '0;
						lvl_q   <= xcd_pkg::LVL_LOW;
					end
				end
				xcd_pkg::XCD_DISABLED: begin
					tmr_q <= '0;
				end
				default: begin
					state_q <= xcd_pkg::XCD_DISABLED;
				end
			endcase
		end
	end

////////////////////////////////////////////////////////////////////////////////
// current commands, all registered

	always_comb begin
		drv_d              = '0;
		drv_d.test_en      = (state_q == xcd_pkg::XCD_DETECT);
		// level reads zero whenever no test current flows
		drv_d.test_lvl     = (state_q == xcd_pkg::XCD_DETECT) ? lvl_q : xcd_pkg::LVL_LOW;
		drv_d.disch_en     = (state_q == xcd_pkg::XCD_DISCHARGE) && latch_q;
		drv_d.short_src_en = (state_q == xcd_pkg::XCD_SHORT_CHK) && vdd_q;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			drv_q             <= '0;
			o_line_loss_latch <= 1'b0;
			o_disabled        <= 1'b0;
		end else begin
			drv_q             <= drv_d;
			o_line_loss_latch <= latch_q;
			o_disabled        <= (state_q == xcd_pkg::XCD_DISABLED);
		end
	end

	assign o_test_en      = drv_q.test_en;
	assign o_test_lvl     = drv_q.test_lvl;
	assign o_disch_en     = drv_q.disch_en;
	assign o_short_src_en = drv_q.short_src_en;

////////////////////////////////////////////////////////////////////////////////
// checks

	chk_disch_latch: assert property (@(posedge i_clk) disable iff (i_rst)
		o_disch_en |-> o_line_loss_latch)
		else $error("discharge without line-loss latch");
	chk_latch_set: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(latch_q) |-> $past(lvl_q) == xcd_pkg::LVL_TOP)
		else $error("latch set before top level");
	chk_zc_wait: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_q == xcd_pkg::XCD_DETECT && zc_evt) |=> state_q == xcd_pkg::XCD_WAIT)
		else $error("crossing did not start wait");
	chk_wait_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_q == xcd_pkg::XCD_WAIT) |=> !o_test_en && !o_disch_en)
		else $error("current during wait");
	chk_lvl_order: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_q == xcd_pkg::XCD_DETECT && $changed(lvl_q) && $past(state_q) ==
		xcd_pkg::XCD_DETECT) |-> lvl_q == $past(lvl_q) + 2'h1)
		else $error("level not increasing by one");
	chk_step_time: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_q == xcd_pkg::XCD_DETECT && lvl_q != xcd_pkg::LVL_TOP && !zc_evt &&
		tmr_q < xcd_pkg::TMR_W'(STEP_CYC - 1)) |=> lvl_q == $past(lvl_q))
		else $error("level advanced early");
	chk_disch_len: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_q == xcd_pkg::XCD_DISCHARGE) |-> tmr_q < xcd_pkg::TMR_W'(DISCH_CYC))
		else $error("discharge too long");
	chk_restart: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_q == xcd_pkg::XCD_DETECT && $past(state_q) != xcd_pkg::XCD_DETECT)
		|-> lvl_q == xcd_pkg::LVL_LOW && tmr_q == '0)
		else $error("detection restarted dirty");
	chk_disabled: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_q == xcd_pkg::XCD_DISABLED) |=> state_q == xcd_pkg::XCD_DISABLED)
		else $error("left disabled state");

	cov_discharge: cover property (@(posedge i_clk) disable iff (i_rst)
		state_q == xcd_pkg::XCD_DISCHARGE);
	cov_wait: cover property (@(posedge i_clk) disable iff (i_rst)
		state_q == xcd_pkg::XCD_WAIT);
	cov_short: cover property (@(posedge i_clk) disable iff (i_rst)
		state_q == xcd_pkg::XCD_DISABLED);

endmodule
`default_nettype wire

// file: testbench/xcd_line_model.sv
// ac-line sensing network model: diode/fet path into the discharge pins
`default_nettype none
module xcd_line_model (
	input  wire logic i_clk,
	input  wire logic i_line_on,
	input  wire logic i_short_on,
	input  wire logic i_test_en,
	output logic      o_zc_cmp,
	output logic      o_short_cmp
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] ph_q = 3'h0;

	// pin only swings past the comparator level while line and test current are both present
	always_ff @(posedge i_clk) begin
		if (i_line_on && i_test_en) begin
			ph_q <= ph_q + 3'h1;
		end
	end
	assign o_zc_cmp    = ph_q[2];
	// a grounded pin sits below the short threshold whatever is sourced
	assign o_short_cmp = i_short_on;
endmodule
`default_nettype wire

// file: testbench/xcd_seq_test.sv
// self-checking bench for the x-cap discharge sequencer
`default_nettype none
module xcd_seq_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  clk, rst, vdd_on, run, line_on, short_on, zc, shc;
	logic                  ten, den, sen, latch, dis;
	logic [1:0]            lvl;
	xcd_pkg::xcd_drive_type drv;
	int                    miscompares, n_tests, cyc, i, prev;
	int                    at [7] = '{10, 30, 50, 70, 110, 150, 190};
	logic [5:0]            ex [7] = '{6'h20, 6'h28, 6'h30, 6'h38, 6'h05, 6'h00, 6'h20};
	assign drv = {ten, lvl, den, sen};
	////////////////////////////////////////////////////////////////////////
	xcd_seq #(.STEP_CYC(20), .LAST_CYC(40), .DISCH_CYC(30), .BLANK_CYC(50)) dut (
		.i_clk(clk), .i_rst(rst), .i_vdd_on(vdd_on), .i_zc_cmp(zc), .i_short_cmp(shc),
		.i_run(run), .o_test_en(ten), .o_test_lvl(lvl), .o_disch_en(den),
		.o_short_src_en(sen), .o_line_loss_latch(latch), .o_disabled(dis));
	xcd_line_model line (.i_clk(clk), .i_line_on(line_on), .i_short_on(short_on),
		.i_test_en(ten), .o_zc_cmp(zc), .o_short_cmp(shc));
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// ceiling well above the roughly 550 cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			end_sim();
		end
	end
	task automatic chk(input string what, input logic [5:0] e, input logic [5:0] g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic rst_dut;
		rst = 1'b1;
		repeat (5) @(negedge clk);
		chk("reset outputs", 6'h00, {drv, latch});
		rst = 1'b0;
	endtask
	task automatic wait_en;
		int k;
		k = 0;
		while (ten !== 1'b1 && k < 400) begin
			@(negedge clk);
			k++;
		end
		chk("detect start", 6'h20, {drv, latch});
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		{rst, vdd_on, run, line_on, short_on} = 5'h10;
		rst_dut();
		vdd_on = 1'b1;
		repeat (8) @(negedge clk);
		chk("short source", 6'h02, {drv, latch});
		run = 1'b1;
		wait_en();
		// staircase, discharge with latch, blanking, restart; line absent throughout
		prev = 0;
		for (i = 0; i < 7; i++) begin
			repeat (at[i] - prev) @(negedge clk);
			prev = at[i];
			chk("staircase row", ex[i], {drv, latch});
		end
		$display("staircase test done");
		repeat (20) @(negedge clk);
		chk("level one", 6'h28, {drv, latch});
		line_on = 1'b1;
		repeat (15) @(negedge clk);
		chk("wait after crossing", 6'h00, {drv, latch});
		line_on = 1'b0;
		repeat (25) @(negedge clk);
		chk("wait holds", 6'h00, {drv, latch});
		wait_en();
		$display("crossing test done");
		short_on = 1'b1;
		run      = 1'b0;
		rst_dut();
		repeat (10) @(negedge clk);
		run = 1'b1;
		repeat (200) @(negedge clk);
		chk("shorted pins", 6'h01, {drv, dis});
		short_on = 1'b0;
		repeat (50) @(negedge clk);
		chk("stays disabled", 6'h01, {drv, dis});
		$display("short test done");
		end_sim();
	end
endmodule
`default_nettype wire
